// *** coproc_consts.vh ***
// Purpose: shared constants of the coprocessor dataflow block
// Assumes: 32-bit classic Wishbone, 100 MHz clk_i
// Notes:   byte addresses, one register per aligned word
`ifndef COPROC_CONSTS_VH
`define COPROC_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define A_CTRL   8'h00
`define A_STAT   8'h04
`define A_DMA    8'h08
`define A_ACNT   8'h0C
`define A_BCNT   8'h10
`define A_BCMP   8'h14
`define A_RLEN   8'h18
`define A_RCNT   8'h1C
`define A_ISTAT  8'h20
`define A_IMASK  8'h24
`define PER_WIN  2'h1
// ****************************************
// processing modes
// ****************************************
`define M_IDLE   3'h0
`define M_COMP   3'h1
`define M_DEC    3'h2
`define M_PAB    3'h3
`define M_PBA    3'h4
// ****************************************
// bus topology codes and fields
// ****************************************
`define BM_A     0
`define BM_B     1
`define BM_TOP   2
`define BM_RSVD  3'h5
`define BM_ONE   3'h7
`define F_AWIDE  3
`define F_BWIDE  4
`define F_APOL   5
`define F_BPOL   6
`define F_AEN    7
`define F_BEN    8
`define I_DONE   0
`define I_ERR    1
`define I_CMP    2
// ****************************************
// reset values and timing
// ****************************************
`define R_DMA    9'h000
`define R_CNT    24'h000000
`define R_IRQ    3'h0
`define CLK_MHZ  100
`define PER_NS   60
`define PER_CYC  ((`PER_NS * `CLK_MHZ + 999) / 1000)
`endif

// *** coproc_dataflow.v ***
// Purpose: port configuration and dataflow of a compression coprocessor
// Assumes: engine core outside, same clock; pins pass two flip-flops
// Notes:   one byte per two cycles through the engine path
//
// What this block does
// - three-bit topology field picks buses and roles
// - top bit zero: dual, low bits pick masters
// - codes 100/110 peripheral access, 101 reserved
// - code 111: one shared bus, both masters
// - dual buses run both ports concurrently
// - compress: port A bytes in, codes to B
// - decompress: B codes in, bytes to A
// - pass-through moves bytes unchanged either way
// - each port counts bytes in 24 bits
// - port B count hits comparator: interrupt
// - per port role, width, pin enable, polarity
// - record length and count drive automatic records
// - dual bus compression sustains full byte rate
// - decompress and pass-through sustain same rate
// - one byte per two clocks on average
// - strap sampled once, only read back in status
// - decompression errors raise a maskable interrupt
// - peripheral window passes accesses to port A
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "coproc_consts.vh"

// ****************************************
// one dma port
// ****************************************
module dma_port (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// configuration
	input  wire        en_i,
	input  wire        master_i,
	input  wire        wide_i,
	input  wire        pol_i,
	input  wire        dir_in_i,
	input  wire        hold_i,
	input  wire        shared_i,
	// override of the data lines
	input  wire        ovr_i,
	input  wire        ovr_oe_i,
	input  wire [15:0] ovr_data_i,
	// pins
	input  wire [15:0] pin_data_i,
	input  wire        pin_strb_i,
	input  wire        pin_rdy_i,
	output reg  [15:0] pin_data_o,
	output reg         pin_data_oe_o,
	output reg         pin_strb_o,
	output reg         pin_strb_oe_o,
	output reg         pin_req_o,
	// byte side
	output wire [15:0] rx_o,
	output wire [7:0]  byte_o,
	output wire        byte_vld_o,
	input  wire        byte_take_i,
	input  wire [7:0]  byte_i,
	input  wire        byte_put_i,
	output wire        space_o,
	output wire        xfer_o,
	output wire [1:0]  nbytes_o
);
	reg  [15:0] d1_q;
	reg  [15:0] d2_q;
	reg         s1_q;
	reg         s2_q;
	reg         sp_q;
	reg         r1_q;
	reg         r2_q;
	reg         act_q;
	reg  [15:0] buf_q;
	reg  [1:0]  cnt_q;
	wire [1:0]  full_n;
	wire        want;
	wire        sedge;
	wire        go_m;

	assign full_n = wide_i ? 2'h2 : 2'h1;
	assign want = en_i & (dir_in_i ? (cnt_q == 2'h0) : (cnt_q == full_n));
	assign sedge = (s2_q ^ pol_i) & ~(sp_q ^ pol_i);
	assign go_m = master_i & want & r2_q & ~hold_i & ~act_q;
	assign xfer_o = master_i ? go_m : (want & sedge);
	assign rx_o = d2_q;
	assign byte_o = buf_q[7:0];
	assign byte_vld_o = dir_in_i & (cnt_q != 2'h0);
	assign space_o = ~dir_in_i & en_i & (cnt_q < full_n);
	assign nbytes_o = full_n;

	// pins cross in through two stages
	always @(posedge clk_i) begin
		d1_q <= pin_data_i;
		d2_q <= d1_q;
		s1_q <= pin_strb_i;
		s2_q <= s1_q;
		sp_q <= s2_q;
		r1_q <= pin_rdy_i;
		r2_q <= r1_q;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			act_q <= 1'b0;
			pin_strb_o <= 1'b0;
			pin_strb_oe_o <= 1'b0;
			pin_req_o <= 1'b0;
			pin_data_o <= 16'h0000;
			pin_data_oe_o <= 1'b0;
		end else begin
			act_q <= go_m;
			pin_strb_o <= go_m ^ pol_i;
			pin_strb_oe_o <= en_i & master_i;
			pin_req_o <= want & ~master_i;
			pin_data_o <= ovr_i ? ovr_data_i : buf_q;
			// shared lines are only driven during own strobe
			if (ovr_i)
				pin_data_oe_o <= ovr_oe_i;
			else
				pin_data_oe_o <= en_i & ~dir_in_i & (~shared_i | go_m);
		end
	end

	// low byte first on a 16-bit port
	always @(posedge clk_i) begin
		if (rst_i) begin
			buf_q <= 16'h0000;
			cnt_q <= 2'h0;
		end else if (!en_i) begin
			cnt_q <= 2'h0;
		end else if (xfer_o) begin
			if (dir_in_i) begin
				buf_q <= d2_q;
				cnt_q <= full_n;
			end else begin
				cnt_q <= 2'h0;
			end
		end else if (dir_in_i & byte_take_i) begin
			buf_q <= {8'h00, buf_q[15:8]};
			cnt_q <= cnt_q - 2'h1;
		end else if (~dir_in_i & byte_put_i) begin
			if (cnt_q == 2'h0)
				buf_q[7:0] <= byte_i;
			else
				buf_q[15:8] <= byte_i;
			cnt_q <= cnt_q + 2'h1;
		end
	end
endmodule

// ****************************************
// top: register file and routing
// ****************************************
module coproc_dataflow (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         irq_o,
	// strap
	input  wire        host_style_strap_i,
	// port A pins
	input  wire [15:0] pa_data_i,
	output wire [15:0] pa_data_o,
	output wire        pa_data_oe_o,
	input  wire        pa_strb_i,
	output wire        pa_strb_o,
	output wire        pa_strb_oe_o,
	input  wire        pa_rdy_i,
	output wire        pa_req_o,
	output reg         pa_per_cs_o,
	output reg         pa_per_rd_o,
	output reg         pa_per_wr_o,
	output reg  [3:0]  pa_per_adr_o,
	// port B pins
	input  wire [15:0] port_b_data_lines_i,
	output wire [15:0] port_b_data_lines_o,
	output wire        port_b_data_lines_oe_o,
	input  wire        pb_strb_i,
	output wire        pb_strb_o,
	output wire        pb_strb_oe_o,
	input  wire        pb_rdy_i,
	output wire        pb_req_o,
	// lz_dictionary_engine
	output reg  [2:0]  eng_mode_o,
	output reg  [7:0]  eng_in_data_o,
	output reg         eng_in_vld_o,
	output reg         eng_in_eor_o,
	input  wire        eng_in_rdy_i,
	input  wire [7:0]  eng_out_data_i,
	input  wire        eng_out_vld_i,
	input  wire        eng_out_eor_i,
	output reg         eng_out_rdy_o,
	input  wire        eng_err_i
);
	localparam P_IDLE = 3'b001;
	localparam P_RUN  = 3'b010;
	localparam P_DONE = 3'b100;
	// full-width copy so the load value is cut on purpose
	localparam [31:0] PER_FULL = `PER_CYC - 1;

	reg  [2:0]  mode_q;
	reg  [8:0]  dma_q;
	reg  [23:0] acnt_q;
	reg  [23:0] bcnt_q;
	reg  [23:0] bcmp_q;
	reg  [23:0] rlen_q;
	reg  [23:0] rcnt_q;
	reg  [23:0] rleft_q;
	reg  [23:0] rbyte_q;
	reg  [2:0]  ist_q;
	reg  [2:0]  imask_q;
	reg         st1_q;
	reg         st2_q;
	reg         strap_q;
	reg         cap_q;
	reg         turn_q;
	reg  [2:0]  per_st_q;
	reg  [7:0]  per_cnt_q;
	reg  [15:0] per_rd_q;
	reg  [31:0] rdat;
	reg  [2:0]  iset;

	wire [2:0]  bm = dma_q[2:0];
	wire        rsvd = (bm == `BM_RSVD);
	wire        shared = (bm == `BM_ONE);
	wire        per_en = bm[`BM_TOP] & ~bm[`BM_A];
	wire        comp = (mode_q == `M_COMP);
	wire        dec = (mode_q == `M_DEC);
	wire        pab = (mode_q == `M_PAB);
	wire        pba = (mode_q == `M_PBA);
	wire        run = comp | dec | pab | pba;
	wire        req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        per_win = (wb_adr_i[7:6] == `PER_WIN) & per_en;
	wire        reg_acc = req & ~per_win;
	wire        wr = reg_acc & wb_we_i;
	wire [7:0]  adr = {wb_adr_i[7:2], 2'h0};
	wire        per_act = ~per_st_q[0];
	wire [15:0] a_rx;
	wire [7:0]  a_byte;
	wire [7:0]  b_byte;
	wire        a_vld;
	wire        b_vld;
	wire        a_space;
	wire        b_space;
	wire        a_xfer;
	wire        b_xfer;
	wire [1:0]  a_nb;
	wire [1:0]  b_nb;

	function [23:0] lanes;
		input [23:0] old;
		input [31:0] nw;
		input [3:0]  sel;
		begin
			lanes = {sel[2] ? nw[23:16] : old[23:16],
				sel[1] ? nw[15:8] : old[15:8],
				sel[0] ? nw[7:0] : old[7:0]};
		end
	endfunction

	// ****************************************
	// topology decode
	// ****************************************
	// reserved code falls back to both slaves
	wire a_mst = bm[`BM_A] & ~rsvd;
	wire b_mst = bm[`BM_B] & ~rsvd;

	// shared bus alternates strobe slots; otherwise only port A holds, during a peripheral access
	wire a_hold = (shared & turn_q) | per_act;
	wire b_hold = shared & ~turn_q;

	// ****************************************
	// routing
	// ****************************************
	wire src_vld = comp ? a_vld : (dec ? b_vld : 1'b0);
	wire [7:0] src = comp ? a_byte : b_byte;
	wire gate = (rleft_q != 24'h000000);
	wire load = src_vld & gate & (~eng_in_vld_o | eng_in_rdy_i);
	wire last = comp & (rbyte_q == rlen_q - 24'h000001);
	wire eo_acc = eng_out_rdy_o & eng_out_vld_i;
	wire pt_ab = pab & a_vld & b_space;
	wire pt_ba = pba & b_vld & a_space;
	wire take_a = (comp & load) | pt_ab;
	wire take_b = (dec & load) | pt_ba;
	wire put_b = (comp & eo_acc) | pt_ab;
	wire put_a = (dec & eo_acc) | pt_ba;
	wire [7:0] to_b = comp ? eng_out_data_i : a_byte;
	wire [7:0] to_a = dec ? eng_out_data_i : b_byte;
	wire sink = comp ? b_space : (dec ? a_space : 1'b0);
	wire [23:0] bnext = bcnt_q + {22'h000000, b_nb};
	wire rdec = (comp & load & last) | (dec & eo_acc & eng_out_eor_i);

	dma_port u_pa (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.en_i         (dma_q[`F_AEN] & run),
		.master_i     (a_mst),
		.wide_i       (dma_q[`F_AWIDE]),
		.pol_i        (dma_q[`F_APOL]),
		.dir_in_i     (comp | pab),
		.hold_i       (a_hold),
		.shared_i     (shared),
		.ovr_i        (per_act),
		.ovr_oe_i     (pa_per_wr_o),
		.ovr_data_i   (wb_dat_i[15:0]),
		.pin_data_i   (pa_data_i),
		.pin_strb_i   (pa_strb_i),
		.pin_rdy_i    (pa_rdy_i),
		.pin_data_o   (pa_data_o),
		.pin_data_oe_o(pa_data_oe_o),
		.pin_strb_o   (pa_strb_o),
		.pin_strb_oe_o(pa_strb_oe_o),
		.pin_req_o    (pa_req_o),
		.rx_o         (a_rx),
		.byte_o       (a_byte),
		.byte_vld_o   (a_vld),
		.byte_take_i  (take_a),
		.byte_i       (to_a),
		.byte_put_i   (put_a),
		.space_o      (a_space),
		.xfer_o       (a_xfer),
		.nbytes_o     (a_nb)
	);

	dma_port u_pb (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.en_i         (dma_q[`F_BEN] & run),
		.master_i     (b_mst),
		.wide_i       (dma_q[`F_BWIDE]),
		.pol_i        (dma_q[`F_BPOL]),
		.dir_in_i     (dec | pba),
		.hold_i       (b_hold),
		.shared_i     (shared),
		.ovr_i        (1'b0),
		.ovr_oe_i     (1'b0),
		.ovr_data_i   (16'h0000),
		.pin_data_i   (port_b_data_lines_i),
		.pin_strb_i   (pb_strb_i),
		.pin_rdy_i    (pb_rdy_i),
		.pin_data_o   (port_b_data_lines_o),
		.pin_data_oe_o(port_b_data_lines_oe_o),
		.pin_strb_o   (pb_strb_o),
		.pin_strb_oe_o(pb_strb_oe_o),
		.pin_req_o    (pb_req_o),
		.rx_o         (),
		.byte_o       (b_byte),
		.byte_vld_o   (b_vld),
		.byte_take_i  (take_b),
		.byte_i       (to_b),
		.byte_put_i   (put_b),
		.space_o      (b_space),
		.xfer_o       (b_xfer),
		.nbytes_o     (b_nb)
	);

	// ****************************************
	// engine handshake
	// ****************************************
	// ready drops after each accept: one byte per two clocks
	always @(posedge clk_i) begin
		if (rst_i) begin
			eng_in_data_o <= 8'h00;
			eng_in_vld_o <= 1'b0;
			eng_in_eor_o <= 1'b0;
			eng_out_rdy_o <= 1'b0;
			eng_mode_o <= `M_IDLE;
		end else begin
			eng_mode_o <= mode_q;
			if (load) begin
				eng_in_data_o <= src;
				eng_in_vld_o <= 1'b1;
				eng_in_eor_o <= last;
			end else if (eng_in_rdy_i) begin
				eng_in_vld_o <= 1'b0;
			end
			eng_out_rdy_o <= sink & ~eo_acc;
		end
	end

	// ****************************************
	// peripheral window
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			per_st_q <= P_IDLE;
			per_cnt_q <= 8'h00;
			per_rd_q <= 16'h0000;
			pa_per_cs_o <= 1'b0;
			pa_per_rd_o <= 1'b0;
			pa_per_wr_o <= 1'b0;
			pa_per_adr_o <= 4'h0;
		end else begin
			case (per_st_q)
			P_IDLE: begin
				if (req & per_win) begin
					per_st_q <= P_RUN;
					per_cnt_q <= PER_FULL[7:0];
					pa_per_cs_o <= 1'b1;
					pa_per_rd_o <= ~wb_we_i;
					pa_per_wr_o <= wb_we_i;
					pa_per_adr_o <= wb_adr_i[5:2];
				end
			end
			P_RUN: begin
				if (per_cnt_q == 8'h00) begin
					per_st_q <= P_DONE;
					per_rd_q <= a_rx;
					pa_per_cs_o <= 1'b0;
					pa_per_rd_o <= 1'b0;
					pa_per_wr_o <= 1'b0;
				end else begin
					per_cnt_q <= per_cnt_q - 8'h01;
				end
			end
			P_DONE: per_st_q <= P_IDLE;
			default: per_st_q <= P_IDLE;
			endcase
		end
	end

	// ****************************************
	// register read mux
	// ****************************************
	always @* begin
		rdat = 32'h00000000;
		case (adr)
		`A_CTRL:  rdat = {29'h00000000, mode_q};
		`A_STAT:  rdat = {29'h00000000, shared, strap_q, ~gate};
		`A_DMA:   rdat = {23'h000000, dma_q};
		`A_ACNT:  rdat = {8'h00, acnt_q};
		`A_BCNT:  rdat = {8'h00, bcnt_q};
		`A_BCMP:  rdat = {8'h00, bcmp_q};
		`A_RLEN:  rdat = {8'h00, rlen_q};
		`A_RCNT:  rdat = {8'h00, rleft_q};
		`A_ISTAT: rdat = {29'h00000000, ist_q};
		`A_IMASK: rdat = {29'h00000000, imask_q};
		default:  rdat = 32'h00000000;
		endcase
	end

	always @* begin
		iset = 3'h0;
		iset[`I_DONE] = rdec & (rleft_q == 24'h000001);
		iset[`I_ERR] = dec & eng_err_i;
		iset[`I_CMP] = b_xfer & (bnext == bcmp_q);
	end

	// ****************************************
	// bus answer and registers
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			irq_o <= 1'b0;
			turn_q <= 1'b0;
		end else begin
			wb_ack_o <= reg_acc | per_st_q[2];
			if (reg_acc)
				wb_dat_o <= rdat;
			else if (per_st_q[2])
				wb_dat_o <= {16'h0000, per_rd_q};
			irq_o <= |(ist_q & imask_q);
			turn_q <= ~turn_q;
		end
	end

	// strap is caught once after reset release
	always @(posedge clk_i) begin
		st1_q <= host_style_strap_i;
		st2_q <= st1_q;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			cap_q <= 1'b0;
			strap_q <= 1'b0;
		end else if (!cap_q) begin
			cap_q <= 1'b1;
			strap_q <= st2_q;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= `M_IDLE;
			dma_q <= `R_DMA;
			acnt_q <= `R_CNT;
			bcnt_q <= `R_CNT;
			bcmp_q <= `R_CNT;
			rlen_q <= `R_CNT;
			rcnt_q <= `R_CNT;
			rleft_q <= `R_CNT;
			rbyte_q <= `R_CNT;
			ist_q <= `R_IRQ;
			imask_q <= `R_IRQ;
		end else begin
			if (wr & (adr == `A_CTRL) & wb_sel_i[0]) begin
				mode_q <= wb_dat_i[2:0];
				rleft_q <= rcnt_q;
				rbyte_q <= `R_CNT;
			end else if (wr & (adr == `A_RCNT)) begin
				rcnt_q <= lanes(rcnt_q, wb_dat_i, wb_sel_i);
				rleft_q <= lanes(rcnt_q, wb_dat_i, wb_sel_i);
			end else begin
				if (rdec)
					rleft_q <= rleft_q - 24'h000001;
				if (comp & load)
					rbyte_q <= last ? `R_CNT : rbyte_q + 24'h000001;
			end
			if (wr & (adr == `A_DMA)) begin
				if (wb_sel_i[0])
					dma_q[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					dma_q[8] <= wb_dat_i[8];
			end
			if (wr & (adr == `A_ACNT))
				acnt_q <= lanes(acnt_q, wb_dat_i, wb_sel_i);
			else if (a_xfer)
				acnt_q <= acnt_q + {22'h000000, a_nb};
			if (wr & (adr == `A_BCNT))
				bcnt_q <= lanes(bcnt_q, wb_dat_i, wb_sel_i);
			else if (b_xfer)
				bcnt_q <= bnext;
			if (wr & (adr == `A_BCMP))
				bcmp_q <= lanes(bcmp_q, wb_dat_i, wb_sel_i);
			if (wr & (adr == `A_RLEN))
				rlen_q <= lanes(rlen_q, wb_dat_i, wb_sel_i);
			if (wr & (adr == `A_IMASK) & wb_sel_i[0])
				imask_q <= wb_dat_i[2:0];
			// a new event wins over a clear in the same cycle
			if (wr & (adr == `A_ISTAT) & wb_sel_i[0])
				ist_q <= (ist_q & ~wb_dat_i[2:0]) | iset;
			else
				ist_q <= ist_q | iset;
		end
	end
endmodule

// *** coproc_dataflow_assertions.sv ***
// Purpose: port-level checker for coproc_dataflow
// Assumes: one clock, synchronous active-high reset
// Notes:   topology is internal, so window checks key on pin activity
`timescale 1ns/1ps
`include "coproc_consts.vh"
// ****************************************
// checker
// ****************************************
module coproc_checker (
	// clock and reset
	input wire        clk_i,
	input wire        rst_i,
	// register bus
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire [7:0]  wb_adr_i,
	input wire        wb_ack_o,
	// port pins
	input wire        pa_per_cs_o,
	input wire        pa_per_rd_o,
	input wire        pa_per_wr_o,
	input wire        pa_strb_oe_o,
	input wire        pa_data_oe_o,
	input wire        port_b_data_lines_oe_o,
	// engine side
	input wire [2:0]  eng_mode_o,
	input wire [7:0]  eng_in_data_o,
	input wire        eng_in_vld_o,
	input wire        eng_in_rdy_i,
	input wire        eng_out_vld_i,
	input wire        eng_out_rdy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	reg_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[7:6] == 2'h0
		|=> wb_ack_o) else $error("register access not answered next cycle");
	per_ack_a: assert property ($rose(pa_per_cs_o) |-> ##[1:10] wb_ack_o)
		else $error("peripheral access not answered");
	per_start_a: assert property ($rose(pa_per_cs_o) |-> wb_stb_i && wb_adr_i[7:6] == 2'h1)
		else $error("peripheral select without window request");
	per_rw_a: assert property (pa_per_cs_o |-> !(pa_per_rd_o && pa_per_wr_o))
		else $error("peripheral read and write together");
	per_slave_a: assert property (pa_per_cs_o |-> !pa_strb_oe_o)
		else $error("peripheral access while port A is master");
	eng_pace_a: assert property (eng_out_vld_i && eng_out_rdy_o |=> !eng_out_rdy_o)
		else $error("engine output accepted on consecutive cycles");
	eng_hold_a: assert property (eng_in_vld_o && !eng_in_rdy_i
		|=> eng_in_vld_o && $stable(eng_in_data_o)) else $error("engine input dropped");
	comp_dir_a: assert property ((eng_mode_o == `M_COMP)[*3] |-> !pa_data_oe_o)
		else $error("port A drives during compression");
	dec_dir_a: assert property ((eng_mode_o == `M_DEC)[*3] |-> !port_b_data_lines_oe_o)
		else $error("port B drives during decompression");
	bypass_a: assert property (eng_mode_o == `M_PAB |-> !eng_in_vld_o)
		else $error("engine fed during pass-through");
	cover property ($rose(pa_per_cs_o));
	cover property (eng_out_vld_i && eng_out_rdy_o);
	cover property (eng_mode_o == `M_DEC ##1 eng_in_vld_o);
endmodule
bind coproc_dataflow coproc_checker coproc_checker_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
	.pa_per_cs_o(pa_per_cs_o), .pa_per_rd_o(pa_per_rd_o), .pa_per_wr_o(pa_per_wr_o),
	.pa_strb_oe_o(pa_strb_oe_o), .pa_data_oe_o(pa_data_oe_o),
	.port_b_data_lines_oe_o(port_b_data_lines_oe_o), .eng_mode_o(eng_mode_o),
	.eng_in_data_o(eng_in_data_o), .eng_in_vld_o(eng_in_vld_o), .eng_in_rdy_i(eng_in_rdy_i),
	.eng_out_vld_i(eng_out_vld_i), .eng_out_rdy_o(eng_out_rdy_o));

// *** dma_peer.sv ***
// Purpose: far-side dma peer for one slave-role port
// Assumes: strobe active level is the inverse of pol
// Notes:   one byte per strobe, strobes sixteen cycles apart
`timescale 1ns/1ps
// ****************************************
// peer
// ****************************************
module dma_peer (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// bench control
	input  wire        go_i,
	input  wire        src_i,
	input  wire        pol_i,
	input  wire [7:0]  n_i,
	// port pins
	input  wire        req_i,
	input  wire [15:0] data_i,
	output reg         strb_o,
	output reg  [15:0] data_o,
	// tallies
	output reg  [7:0]  cnt_o,
	output reg  [15:0] sum_o
);
	reg [3:0] t_q;
	// idle lines toggle every cycle so a stale byte never passes
	always @(posedge clk_i) begin
		if (rst_i || !go_i) begin
			t_q    <= 4'h0;
			cnt_o  <= 8'h00;
			sum_o  <= 16'h0000;
			strb_o <= pol_i;
			data_o <= rst_i ? 16'hA5A5 : ~data_o;
		end else if (t_q != 4'h0) begin
			t_q <= t_q + 4'h1;
			if (t_q == 4'h2)
				strb_o <= pol_i;
			if (t_q > 4'h5)
				data_o <= ~data_o;
		end else if (req_i && cnt_o != n_i) begin
			t_q    <= 4'h1;
			strb_o <= ~pol_i;
			cnt_o  <= cnt_o + 8'h01;
			sum_o  <= sum_o + (src_i ? 8'h30 + cnt_o : data_i[7:0]);
			if (src_i)
				data_o <= {8'hFF, 8'h30 + cnt_o};
		end else
			data_o <= ~data_o;
	end
endmodule

// *** test_coproc_dataflow.sv ***
// Purpose: self-checking bench for coproc_dataflow
// Assumes: both ports slaves to peers, engine stand-in echoes bytes
// Notes:   echo engine keeps byte sums equal on every data path
`timescale 1ns/1ps
`include "coproc_consts.vh"
module test_coproc_dataflow;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	reg         clk_i, rst_i, cyc, stb, we, strap, err, go, a_src, a_pol;
	reg         e_vld_q, e_eor_q;
	reg  [7:0]  adr, e_dat_q;
	reg  [31:0] wdat, rdat;
	integer     lat, mismatches, n_tests, m, k;
	row_t       rows [0:7];
	wire [31:0] wb_dat;
	wire        ack, irq, pa_oe, pa_so, pa_soe, pa_req, pa_ps, pb_oe, pb_so, pb_soe, pb_req, pb_ps;
	wire        ein_v, ein_eor, eout_rdy;
	wire [15:0] pa_do, pb_do, pa_pd, pb_pd, pa_bus, pb_bus, a_sum, b_sum;
	wire [7:0]  a_cnt, b_cnt, ein_d;
	wire [3:0]  per_adr;
	// wire level from the coprocessor's enable, else the peer drives
	assign pa_bus = pa_oe ? pa_do : pa_pd;
	assign pb_bus = pb_oe ? pb_do : pb_pd;
	coproc_dataflow coproc_dataflow_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat), .wb_ack_o(ack), .irq_o(irq), .host_style_strap_i(strap),
		.pa_data_i(pa_bus), .pa_data_o(pa_do), .pa_data_oe_o(pa_oe),
		.pa_strb_i(pa_soe ? pa_so : pa_ps), .pa_strb_o(pa_so), .pa_strb_oe_o(pa_soe),
		.pa_rdy_i(1'b0), .pa_req_o(pa_req), .pa_per_cs_o(), .pa_per_rd_o(), .pa_per_wr_o(),
		.pa_per_adr_o(per_adr), .port_b_data_lines_i(pb_bus), .port_b_data_lines_o(pb_do),
		.port_b_data_lines_oe_o(pb_oe), .pb_strb_i(pb_soe ? pb_so : pb_ps),
		.pb_strb_o(pb_so), .pb_strb_oe_o(pb_soe), .pb_rdy_i(1'b0), .pb_req_o(pb_req),
		.eng_mode_o(), .eng_in_data_o(ein_d), .eng_in_vld_o(ein_v), .eng_in_eor_o(ein_eor),
		.eng_in_rdy_i(!e_vld_q), .eng_out_data_i(e_dat_q), .eng_out_vld_i(e_vld_q),
		.eng_out_eor_i(e_eor_q), .eng_out_rdy_o(eout_rdy), .eng_err_i(err));
	dma_peer peer_a (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .src_i(a_src), .pol_i(a_pol),
		.n_i(8'h06), .req_i(pa_req), .data_i(pa_bus), .strb_o(pa_ps), .data_o(pa_pd),
		.cnt_o(a_cnt), .sum_o(a_sum));
	dma_peer peer_b (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .src_i(!a_src), .pol_i(a_pol),
		.n_i(8'h06), .req_i(pb_req), .data_i(pb_bus), .strb_o(pb_ps), .data_o(pb_pd),
		.cnt_o(b_cnt), .sum_o(b_sum));
	// one-deep echo engine; ready falls while a byte waits
	always @(posedge clk_i) begin
		if (rst_i)
			e_vld_q <= 1'b0;
		else if (ein_v && !e_vld_q) begin
			e_vld_q <= 1'b1;
			e_dat_q <= ein_d;
			e_eor_q <= ein_eor;
		end else if (eout_rdy)
			e_vld_q <= 1'b0;
	end
	always #5 clk_i = ~clk_i;
	// ****************************************
	// tasks
	// ****************************************
	task chk(input [31:0] got, input [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wb(input w, input [7:0] a, input [31:0] d);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		lat = 0;
		@(posedge clk_i);
		while (ack !== 1'b1 && lat < 40) begin
			@(posedge clk_i);
			lat = lat + 1;
		end
		if (lat == 40)
			mismatches = mismatches + 1;
		rdat = wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask
	task pulse_err;
		@(posedge clk_i);
		err <= 1'b1;
		@(posedge clk_i);
		err <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task end_sim;
		$display("checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches = mismatches + 1;
		end_sim;
	end
	initial begin
		{clk_i, cyc, stb, we, err, go, a_src, a_pol} = 8'h00;
		{rst_i, strap} = 2'h3;
		adr = 8'h00;
		wdat = 32'h0;
		mismatches = 0;
		n_tests = 0;
		rows[0] = '{1'b0, `A_DMA, 32'h0, 32'h0};
		rows[1] = '{1'b0, `A_ACNT, 32'h0, 32'h0};
		rows[2] = '{1'b0, `A_BCNT, 32'h0, 32'h0};
		rows[3] = '{1'b0, `A_ISTAT, 32'h0, 32'h0};
		rows[4] = '{1'b1, `A_BCMP, 32'hFFABCDEF, 32'h00ABCDEF};
		rows[5] = '{1'b1, `A_RLEN, 32'h6, 32'h6};
		rows[6] = '{1'b1, 8'h30, 32'hFFFFFFFF, 32'h0};
		rows[7] = '{1'b1, `A_DMA, 32'h19B, 32'h19B};
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (k = 0; k < 8; k++) begin
			if (rows[k].w)
				wb(1'b1, rows[k].a, rows[k].d);
			wb(1'b0, rows[k].a, 32'h0);
			chk(rdat, rows[k].e);
		end
		// strobe enables only show while a mode runs
		wb(1'b1, `A_CTRL, 32'h3);
		for (k = 0; k < 8; k++) begin
			if (k == 5)
				continue;
			wb(1'b1, `A_DMA, 32'h180 | k);
			repeat (4) @(posedge clk_i);
			chk({30'h0, pa_soe, pb_soe}, {30'h0, k[0] && !(k[2] && !k[1]), k[1]});
			wb(1'b0, `A_STAT, 32'h0);
			chk(rdat & 32'h6, (k == 7) ? 32'h6 : 32'h2);
		end
		wb(1'b1, `A_CTRL, 32'h0);
		wb(1'b1, `A_DMA, 32'h184);
		wb(1'b1, 8'h44, 32'h5A);
		chk({31'h0, lat > `PER_CYC}, 32'h1);
		wb(1'b0, 8'h48, 32'h0);
		chk({28'h0, per_adr}, 32'h2);
		wb(1'b1, `A_DMA, 32'h180);
		wb(1'b1, 8'h44, 32'h5A);
		chk(lat, 32'h1);
		wb(1'b1, `A_BCMP, 32'h6);
		for (m = 1; m < 5; m++) begin
			a_src <= (m == 1 || m == 3);
			a_pol <= (m == 3);
			wb(1'b1, `A_DMA, (m == 3) ? 32'h1E0 : 32'h180);
			wb(1'b1, `A_ACNT, 32'h0);
			wb(1'b1, `A_BCNT, 32'h0);
			wb(1'b1, `A_RLEN, 32'h6);
			wb(1'b1, `A_RCNT, 32'h1);
			wb(1'b1, `A_CTRL, m);
			go <= 1'b1;
			lat = 0;
			while ((a_src ? b_cnt : a_cnt) !== 8'h06 && lat < 2000) begin
				@(posedge clk_i);
				lat = lat + 1;
			end
			if (lat == 2000)
				mismatches = mismatches + 1;
			repeat (16) @(posedge clk_i);
			chk(a_src ? b_sum : a_sum, 32'h12F);
			wb(1'b0, `A_ACNT, 32'h0);
			chk(rdat, 32'h6);
			wb(1'b0, `A_BCNT, 32'h0);
			chk(rdat, 32'h6);
			wb(1'b1, `A_CTRL, 32'h0);
			go <= 1'b0;
			repeat (20) @(posedge clk_i);
		end
		wb(1'b0, `A_ISTAT, 32'h0);
		chk(rdat & 32'h4, 32'h4);
		chk(rdat & 32'h1, 32'h1);
		wb(1'b1, `A_IMASK, 32'h4);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, `A_ISTAT, 32'h4);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, `A_IMASK, 32'h2);
		wb(1'b1, `A_CTRL, 32'h2);
		pulse_err;
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, `A_ISTAT, 32'h2);
		wb(1'b1, `A_CTRL, 32'h1);
		pulse_err;
		wb(1'b0, `A_ISTAT, 32'h0);
		chk(rdat & 32'h2, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// mid-run reset: counters clear, strap is caught again
		strap <= 1'b0;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `A_STAT, 32'h0);
		chk(rdat & 32'h2, 32'h0);
		wb(1'b0, `A_ACNT, 32'h0);
		chk(rdat, 32'h0);
		end_sim;
	end
endmodule
